// *** verilog/mode_reg_pkg.sv ***
// shared constants for the mode-register programming block
package mode_reg_pkg;
  // apb register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_BASE = 12'h008;
  localparam logic [11:0] OFS_EXT1 = 12'h00c;
  localparam logic [11:0] OFS_EXT2 = 12'h010;
  localparam logic [11:0] OFS_EXT3 = 12'h014;
  localparam logic [11:0] OFS_BURST = 12'h018;
  localparam logic [11:0] OFS_DECODE = 12'h01c;
  // ctrl register bits
  localparam int CTRL_SELF_REFRESH_EXIT = 0;
  localparam int CTRL_BURST_START = 1;
  // status register bits
  localparam int STAT_BASE_VALID = 0;
  localparam int STAT_EXT1_VALID = 1;
  localparam int STAT_EXT2_VALID = 2;
  localparam int STAT_EXT3_VALID = 3;
  localparam int STAT_DLL_ON = 4;
  localparam int STAT_DLL_LOCKED = 5;
  // mode register width and reset contents
  localparam int MR_WIDTH = 13;
  localparam logic [12:0] MR_RESET = 13'h0000;
  // base register fields
  localparam int BASE_BL_LSB = 0;
  localparam int BASE_BT_BIT = 3;
  localparam int BASE_CL_LSB = 4;
  localparam int BASE_TM_BIT = 7;
  localparam int BASE_DLLRST_BIT = 8;
  localparam int BASE_WR_LSB = 9;
  // first extended register fields
  localparam int EXT1_DLLDIS_BIT = 0;
  localparam int EXT1_WEAK_BIT = 1;
  localparam int EXT1_ODT0_BIT = 2;
  localparam int EXT1_AL_LSB = 3;
  localparam int EXT1_ODT1_BIT = 6;
  localparam int EXT1_CAL_LSB = 7;
  localparam int EXT1_DQSN_DIS_BIT = 10;
  // second extended register fields
  localparam int EXT2_PAR_LSB = 0;
  localparam int EXT2_DCC_BIT = 3;
  localparam int EXT2_HTSR_BIT = 7;
  // burst length codes
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  // clocks the dll needs after being enabled before a read
  localparam logic [7:0] DLL_LOCK_CLOCKS = 8'hc8;
  // which mode register a load-mode command addresses
  typedef enum logic [1:0] {
    MR_BASE = 2'b00,
    MR_EXT1 = 2'b01,
    MR_EXT2 = 2'b10,
    MR_EXT3 = 2'b11
  } mr_sel_t;
endpackage : mode_reg_pkg

// *** verilog/cmd_pin_sync.sv ***
`timescale 1ns/10ps
// three-stage synchroniser for the command and address pins
module cmd_pin_sync #(
  parameter int WIDTH = 19
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // raw pins and filtered result
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sync_state_t;
  sync_state_t st_q;
  sync_state_t st_d;

  initial begin
    if (WIDTH < 1) $error("cmd_pin_sync width must be positive");
  end

  // a bit counts only when stages two and three agree; s1 feeds s2 only
  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.held[i] = st_q.s3[i];
      end
    end
  end

  // pins idle high (deselect) out of reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign pinOut = st_q.held;
endmodule : cmd_pin_sync

// *** verilog/burst_order.sv ***
`timescale 1ns/10ps
// column order of one beat within a burst
module burst_order (
  // burst setup
  input wire logic [2:0] startCol,
  input wire logic interleaved,
  input wire logic lengthEight,
  // beat index and resulting column bits
  input wire logic [2:0] beat,
  output logic [2:0] column
);
  logic [1:0] low;
  logic high;

  // low pair wraps in a group of four; upper bit flips on second group
  always_comb begin
    if (interleaved) begin
      low = startCol[1:0] ^ beat[1:0];
    end else begin
      low = 2'(startCol[1:0] + beat[1:0]);
    end
    high = lengthEight ? (startCol[2] ^ beat[2]) : startCol[2];
    column = {high, low};
  end
endmodule : burst_order

// *** verilog/ddr2_mode_regs.sv ***
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
// mode-register programming logic with apb view and decoded fields

// What this block does
// - Four strobes and bank bits low, clock enable high, loads address into base register.
// - Burst length from base bits 0..2, burst order from bit 3.
// - Read latency from base bits 4..6, whole clocks only.
// - Base bit 7 is test mode, kept low; bit 8 resets the loop.
// - Below 1.875ns clock, no auto-precharge writes; recovery field zero.
// - Burst column order wraps in groups of four, sequential or interleaved.
// - Loop enabled needs 200 clocks before read; self-refresh exit re-enables.
// - Bank bit 0 high, bit 1 low selects first extended; loop disable, weak drive.
// - Extended one: additive latency bits 3..5, termination 2 and 6, calibration 7..9.
// - Extended one bit 10 disables complementary strobe, then ignored.
// - Bank bit 1 high, bit 0 low selects second extended; bit 7 high-temperature refresh.
// - Second extended reserved bits zero; bit 3 duty-cycle corrector.
// - Partial-array refresh range from low three bits of second extended.
// - Both bank bits high select the third extended register.
module ddr2_mode_regs import mode_reg_pkg::*; #(
  parameter int ROW_BITS = 13
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // command pins from the controller; the four strobes active low, clock enable active high
  input wire logic chipSel_b,
  input wire logic rowStrobe_b,
  input wire logic colStrobe_b,
  input wire logic writeEn_b,
  input wire logic clockEn,
  input wire logic [1:0] bankAddr,
  input wire logic [ROW_BITS-1:0] rowAddr,
  input wire logic strobeN,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded mode fields to the array logic
  output logic [2:0] burst_length,
  output logic burstInterleaved,
  output logic [2:0] readLatency,
  output logic testMode,
  output logic dllEnabled,
  output logic dllResetPulse,
  output logic readAllowed,
  output logic weakDrive,
  output logic [2:0] additive_latency,
  output logic [1:0] on_die_termination,
  output logic [2:0] driver_impedance_calibration,
  output logic complStrobeUsed,
  output logic complStrobe,
  output logic highTempRefresh,
  output logic duty_cycle_corrector,
  output logic [2:0] partial_array_refresh,
  output logic [2:0] burstColumn
);
  localparam int PIN_W = 6 + ROW_BITS;

  typedef struct packed {
    logic [MR_WIDTH-1:0] base;
    logic [MR_WIDTH-1:0] ext1;
    logic [MR_WIDTH-1:0] ext2;
    logic [MR_WIDTH-1:0] ext3;
    logic [3:0] written;
    logic dllReset;
    logic [7:0] lockCount;
    logic [2:0] burstStart;
    logic [2:0] beat;
    logic burstRun;
    logic [2:0] column;
    logic [1:0] lastSel;
    logic lastLoad;
    logic [31:0] rdata;
  } mr_state_t;

  mr_state_t st_q;
  mr_state_t st_d;
  logic [PIN_W-1:0] pinsRaw;
  logic [PIN_W-1:0] pinsSync;
  logic [2:0] beatColumn;
  logic loadCmd;
  mr_sel_t regSel;
  logic [MR_WIDTH-1:0] addrBits;
  logic apbWrite;
  logic apbRead;
  logic [2:0] burstLast;
  logic [2:0] burstCode;

  initial begin
    if (ROW_BITS != MR_WIDTH) $error("ddr2_mode_regs row width must equal register width");
  end

  // true when a mapped register lives at this byte address
  function automatic logic mapped(input logic [11:0] addr);
    mapped = (addr == OFS_CTRL) || (addr == OFS_STATUS) || (addr == OFS_BASE) ||
             (addr == OFS_EXT1) || (addr == OFS_EXT2) || (addr == OFS_EXT3) ||
             (addr == OFS_BURST) || (addr == OFS_DECODE);
  endfunction : mapped

  // pins cross into our clock through the three-stage filter
  assign pinsRaw = {chipSel_b, rowStrobe_b, colStrobe_b, writeEn_b, bankAddr, rowAddr};

  cmd_pin_sync #(
    .WIDTH(PIN_W)
  ) pinSync (
    .clock(clock),
    .rst_b(rst_b),
    .pinIn(pinsRaw),
    .pinOut(pinsSync)
  );

  // load-mode is all four strobes low; bank bits pick the register
  assign loadCmd = (pinsSync[PIN_W-1 -: 4] == 4'h0);
  assign regSel = mr_sel_t'(pinsSync[ROW_BITS +: 2]);
  assign addrBits = pinsSync[ROW_BITS-1:0];

  // apb strobes: zero wait state, writes land in the access phase
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // burst end depends on length 4 or 8; other codes run as four
  assign burstCode = st_q.base[BASE_BL_LSB +: 3];
  assign burstLast = (burstCode == BL_CODE_8) ? 3'h7 : 3'h3;

  burst_order order (
    .startCol(st_q.burstStart),
    .interleaved(st_q.base[BASE_BT_BIT]),
    .lengthEight(burstCode == BL_CODE_8),
    .beat(st_q.beat),
    .column(beatColumn)
  );

  // next-state logic for registers, lock counter, burst walker and apb
  always_comb begin
    st_d = st_q;
    st_d.dllReset = 1'b0;
    st_d.lastLoad = loadCmd;
    // clock enable gates the load; the controller guarantees idle banks
    if (loadCmd && clockEn) begin
      st_d.lastSel = regSel;
      st_d.written[regSel] = 1'b1;
      unique case (regSel)
        MR_BASE: begin
          st_d.base = addrBits;
          // a held pattern reloads every clock; pulse only on its first load
          st_d.dllReset = addrBits[BASE_DLLRST_BIT] && !st_q.lastLoad;
        end
        MR_EXT1: begin
          st_d.ext1 = addrBits;
        end
        MR_EXT2: begin
          st_d.ext2 = addrBits;
        end
        MR_EXT3: begin
          st_d.ext3 = addrBits;
        end
      endcase
    end
    // loop relock: any enable or reset restarts the count
    if (st_q.ext1[EXT1_DLLDIS_BIT]) begin
      st_d.lockCount = 8'h00;
    end else if (st_d.dllReset ||
                 (loadCmd && clockEn && regSel == MR_EXT1 && !addrBits[EXT1_DLLDIS_BIT])) begin
      st_d.lockCount = 8'h00;
    end else if (st_q.lockCount != DLL_LOCK_CLOCKS) begin
      st_d.lockCount = 8'(st_q.lockCount + 8'h01);
    end
    // leaving self refresh brings the loop back on by itself
    if (apbWrite && paddr == OFS_CTRL && pwdata[CTRL_SELF_REFRESH_EXIT]) begin
      st_d.ext1[EXT1_DLLDIS_BIT] = 1'b0;
      st_d.lockCount = 8'h00;
    end
    // software-started burst walks the column order one beat per clock
    if (st_q.burstRun) begin
      st_d.column = beatColumn;
      if (st_q.beat == burstLast) begin
        st_d.burstRun = 1'b0;
        st_d.beat = 3'h0;
      end else begin
        st_d.beat = 3'(st_q.beat + 3'h1);
      end
    end
    if (apbWrite && paddr == OFS_CTRL && pwdata[CTRL_BURST_START] && !st_q.burstRun) begin
      st_d.burstRun = 1'b1;
      st_d.beat = 3'h0;
    end
    if (apbWrite && paddr == OFS_BURST) begin
      st_d.burstStart = pwdata[2:0];
    end
    // read data captured in setup, valid through the access phase
    if (apbRead) begin
      st_d.rdata = 32'h0000_0000;
      if (paddr == OFS_STATUS) begin
        st_d.rdata[3:0] = st_q.written;
        st_d.rdata[STAT_DLL_ON] = !st_q.ext1[EXT1_DLLDIS_BIT];
        st_d.rdata[STAT_DLL_LOCKED] = readAllowed;
      end else if (paddr == OFS_CTRL) begin
        st_d.rdata[CTRL_BURST_START] = st_q.burstRun;
      end else if (paddr == OFS_BASE) begin
        st_d.rdata[MR_WIDTH-1:0] = st_q.base;
      end else if (paddr == OFS_EXT1) begin
        st_d.rdata[MR_WIDTH-1:0] = st_q.ext1;
      end else if (paddr == OFS_EXT2) begin
        st_d.rdata[MR_WIDTH-1:0] = st_q.ext2;
      end else if (paddr == OFS_EXT3) begin
        st_d.rdata[MR_WIDTH-1:0] = st_q.ext3;
      end else if (paddr == OFS_BURST) begin
        st_d.rdata[2:0] = st_q.burstStart;
        st_d.rdata[10:8] = st_q.column;
        st_d.rdata[15:12] = {1'b0, st_q.beat};
      end else if (paddr == OFS_DECODE) begin
        st_d.rdata[1:0] = st_q.lastSel;
        st_d.rdata[2] = st_q.lastLoad;
      end
    end
  end

  // contents have no defined power-up value; zero is just a known start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.base <= MR_RESET;
      st_q.ext1 <= MR_RESET;
      st_q.ext2 <= MR_RESET;
      st_q.ext3 <= MR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // base register fields
  assign burst_length = st_q.base[BASE_BL_LSB +: 3];
  assign burstInterleaved = st_q.base[BASE_BT_BIT];
  assign readLatency = st_q.base[BASE_CL_LSB +: 3];
  assign testMode = st_q.base[BASE_TM_BIT];
  assign dllResetPulse = st_q.dllReset;

  // first extended register fields
  assign dllEnabled = !st_q.ext1[EXT1_DLLDIS_BIT];
  assign weakDrive = st_q.ext1[EXT1_WEAK_BIT];
  assign additive_latency = st_q.ext1[EXT1_AL_LSB +: 3];
  assign on_die_termination = {st_q.ext1[EXT1_ODT1_BIT], st_q.ext1[EXT1_ODT0_BIT]};
  assign driver_impedance_calibration = st_q.ext1[EXT1_CAL_LSB +: 3];
  assign complStrobeUsed = !st_q.ext1[EXT1_DQSN_DIS_BIT];
  // single-ended mode: complementary strobe treated as don't care
  assign complStrobe = complStrobeUsed ? strobeN : 1'b1;

  // second extended register fields
  assign highTempRefresh = st_q.ext2[EXT2_HTSR_BIT];
  assign duty_cycle_corrector = st_q.ext2[EXT2_DCC_BIT];
  assign partial_array_refresh = st_q.ext2[EXT2_PAR_LSB +: 3];

  // reads are gated until the loop has had its 200 clocks
  assign readAllowed = dllEnabled && (st_q.lockCount == DLL_LOCK_CLOCKS);

  assign burstColumn = st_q.column;
  assign prdata = st_q.rdata;
endmodule : ddr2_mode_regs

// *** dv/mode_regs_props.sv ***
`timescale 1ns/10ps
// checker for the mode-register block, bound to its top module
module mode_regs_props #(
  parameter int ROW_BITS = 13
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // command pins
  input wire logic chipSel_b,
  input wire logic rowStrobe_b,
  input wire logic colStrobe_b,
  input wire logic writeEn_b,
  input wire logic clockEn,
  input wire logic [1:0] bankAddr,
  input wire logic [ROW_BITS-1:0] rowAddr,
  input wire logic strobeN,
  // decoded fields
  input wire logic [2:0] burst_length,
  input wire logic burstInterleaved,
  input wire logic [2:0] readLatency,
  input wire logic testMode,
  input wire logic dllEnabled,
  input wire logic dllResetPulse,
  input wire logic readAllowed,
  input wire logic weakDrive,
  input wire logic [2:0] additive_latency,
  input wire logic [1:0] on_die_termination,
  input wire logic [2:0] driver_impedance_calibration,
  input wire logic complStrobeUsed,
  input wire logic complStrobe,
  input wire logic highTempRefresh,
  input wire logic duty_cycle_corrector,
  input wire logic [2:0] partial_array_refresh
);
  logic ld;
  logic [7:0] sincePulse_d;
  logic [7:0] sincePulse_q;
  // load-mode command as seen at the pins, clock enable included
  assign ld = !chipSel_b && !rowStrobe_b && !colStrobe_b && !writeEn_b && clockEn;
  // clocks since the last loop reset, saturating so it never wraps
  always_comb begin
    sincePulse_d = sincePulse_q;
    if (dllResetPulse) begin
      sincePulse_d = 8'h00;
    end else if (sincePulse_q != 8'hff) begin
      sincePulse_d = sincePulse_q + 8'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sincePulse_q <= 8'h00;
    end else begin
      sincePulse_q <= sincePulse_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // pattern held long enough to pass the three-flop pin filter
  sequence held(logic [1:0] b);
    (ld && bankAddr == b && $stable(rowAddr))[*6];
  endsequence
  AST_BASE_FIELDS: assert property (held(2'h0) |-> burst_length == rowAddr[2:0]
    && burstInterleaved == rowAddr[3] && readLatency == rowAddr[6:4] && testMode == rowAddr[7])
    else $error("base fields differ from loaded row bits");
  AST_EXT1_FIELDS: assert property (held(2'h1) |-> dllEnabled == !rowAddr[0]
    && weakDrive == rowAddr[1] && additive_latency == rowAddr[5:3]
    && on_die_termination == {rowAddr[6], rowAddr[2]}
    && driver_impedance_calibration == rowAddr[9:7] && complStrobeUsed == !rowAddr[10])
    else $error("first extended fields differ from loaded row bits");
  AST_EXT2_FIELDS: assert property (held(2'h2) |-> highTempRefresh == rowAddr[7]
    && duty_cycle_corrector == rowAddr[3] && partial_array_refresh == rowAddr[2:0])
    else $error("second extended fields differ from loaded row bits");
  AST_EXT3_NO_SIDE: assert property (held(2'h3) |-> $stable(burst_length)
    && $stable(additive_latency) && $stable(highTempRefresh))
    else $error("third extended load disturbed another register");
  AST_HOLD: assert property ((!ld)[*8] |-> $stable(readLatency)
    && $stable(weakDrive) && $stable(partial_array_refresh))
    else $error("mode field changed with no load command");
  AST_STROBE_IGNORED: assert property (!complStrobeUsed |-> complStrobe)
    else $error("complementary strobe not ignored when disabled");
  AST_DLL_PULSE: assert property (dllResetPulse |=> !dllResetPulse)
    else $error("loop reset pulse longer than one clock");
  AST_READ_LOCK: assert property (readAllowed |-> dllEnabled && sincePulse_q >= 8'd195)
    else $error("read allowed before loop lock time");
endmodule : mode_regs_props

bind ddr2_mode_regs mode_regs_props #(.ROW_BITS(ROW_BITS)) mode_regs_props_i (.*);

// *** dv/ctrl_model.sv ***
`timescale 1ns/10ps
// memory controller model issuing load-mode commands on the pins
module ctrl_model (
  // clock
  input wire logic clock,
  // command pins
  output logic chipSel_b,
  output logic rowStrobe_b,
  output logic colStrobe_b,
  output logic writeEn_b,
  output logic clockEn,
  output logic [1:0] bankAddr,
  output logic [12:0] rowAddr
);
  // deselected at power-up, all banks taken as precharged
  initial begin
    {chipSel_b, rowStrobe_b, colStrobe_b, writeEn_b} = 4'hf;
    clockEn = 1'b1;
    bankAddr = 2'h0;
    rowAddr = 13'h0000;
  end
  // one load held past the pin filter; values chosen by caller
  task automatic mode_set(input logic [1:0] bank, input logic [12:0] val, input logic cke);
    @(posedge clock);
    {chipSel_b, rowStrobe_b, colStrobe_b, writeEn_b} <= 4'h0;
    clockEn <= cke;
    bankAddr <= bank;
    rowAddr <= val;
    repeat (7) @(posedge clock);
    chipSel_b <= 1'b1;
    // released lines must not keep showing the old value
    rowAddr <= ~val;
    bankAddr <= ~bank;
    repeat (8) @(posedge clock); // mode_set_cycle_time gap
    clockEn <= 1'b1; // late, so a filtered command never meets a raised enable
  endtask : mode_set
endmodule : ctrl_model

// *** dv/ddr2_mode_register_programming_tb.sv ***
`timescale 1ns/10ps
// self-checking bench for the mode-register block
module ddr2_mode_register_programming_tb import mode_reg_pkg::*; ;
  logic clock, rst_b, strobeN, psel, penable, pwrite, pready, pslverr;
  logic chipSel_b, rowStrobe_b, colStrobe_b, writeEn_b, clockEn;
  logic [1:0] bankAddr, on_die_termination;
  logic [12:0] rowAddr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] burst_length, readLatency, additive_latency, driver_impedance_calibration;
  logic [2:0] partial_array_refresh, burstColumn;
  logic burstInterleaved, testMode, dllEnabled, dllResetPulse, readAllowed, weakDrive;
  logic complStrobeUsed, complStrobe, highTempRefresh, duty_cycle_corrector;
  int errTotal = 0;
  int nChecks = 0;
  ddr2_mode_regs ddr2_mode_regs_i (.*);
  ctrl_model ctrl_model_i (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic se);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errTotal++;
      finish_test();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [2:0] col_at(input logic [2:0] s, input logic il, input logic l8,
                                        input int i);
    logic [2:0] b;
    b = 3'(i);
    col_at[1:0] = il ? (s[1:0] ^ b[1:0]) : (s[1:0] + b[1:0]);
    col_at[2] = s[2] ^ (l8 & b[2]);
  endfunction : col_at
  task automatic t_load();
    logic [31:0] d;
    logic s;
    apb(1'b0, OFS_STATUS, 32'h0, d, s);
    chk("written flags", 32'h0, d[3:0]);
    ctrl_model_i.mode_set(2'h2, 13'h008d, 1'b1);
    ctrl_model_i.mode_set(2'h3, 13'h0000, 1'b1);
    ctrl_model_i.mode_set(2'h1, 13'h001e, 1'b1);
    ctrl_model_i.mode_set(2'h0, 13'h0a5b, 1'b1);
    chk("burst_length", 32'h3, burst_length);
    chk("burstInterleaved", 32'h1, burstInterleaved);
    chk("readLatency", 32'h5, readLatency);
    chk("testMode", 32'h0, testMode);
    chk("weakDrive", 32'h1, weakDrive);
    chk("ext1 fields", 32'h0d0, {additive_latency, on_die_termination, 1'b0,
        driver_impedance_calibration});
    chk("ext2 fields", 32'h1d, {highTempRefresh, duty_cycle_corrector,
        partial_array_refresh});
    ctrl_model_i.mode_set(2'h0, 13'h0032, 1'b0); // clock enable low: refused
    apb(1'b1, OFS_BASE, 32'h0, d, s);
    apb(1'b0, OFS_BASE, 32'h0, d, s);
    chk("base contents", 32'h0a5b, d);
    apb(1'b0, OFS_EXT1, 32'h0, d, s);
    chk("ext1 contents", 32'h001e, d);
    apb(1'b0, OFS_EXT2, 32'h0, d, s);
    chk("ext2 contents", 32'h008d, d);
    apb(1'b0, OFS_EXT3, 32'h0, d, s);
    chk("ext3 contents", 32'h0, d);
    apb(1'b0, OFS_STATUS, 32'h0, d, s);
    chk("written flags", 32'hf, d[3:0]);
    apb(1'b0, 12'h020, 32'h0, d, s);
    chk("unmapped error", 32'h1, s);
    chk("unmapped data", 32'h0, d);
    $display("t_load done");
  endtask : t_load
  task automatic t_dll();
    logic [31:0] d;
    logic s;
    int n;
    ctrl_model_i.mode_set(2'h0, 13'h0b5b, 1'b1); // loop reset requested
    chk("readAllowed early", 32'h0, readAllowed);
    n = 0;
    while (readAllowed !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("lock clocks", 32'h1, (n + 15 >= 198) && (n + 15 <= 206));
    ctrl_model_i.mode_set(2'h1, 13'h041f, 1'b1); // loop off, single strobe
    chk("dllEnabled off", 32'h0, dllEnabled);
    chk("readAllowed off", 32'h0, readAllowed);
    chk("complStrobe ignored", 32'h1, complStrobe);
    apb(1'b1, OFS_CTRL, 32'h1, d, s);
    @(negedge clock);
    chk("self refresh exit", 32'h1, dllEnabled);
    ctrl_model_i.mode_set(2'h1, 13'h021e, 1'b1); // adjustable, same latency
    chk("cal adjustable", 32'h4, driver_impedance_calibration);
    ctrl_model_i.mode_set(2'h1, 13'h001e, 1'b1); // calibration exit
    ctrl_model_i.mode_set(2'h1, 13'h039e, 1'b1); // default impedance state
    chk("cal default", 32'h7, driver_impedance_calibration);
    ctrl_model_i.mode_set(2'h1, 13'h001e, 1'b1); // exit with zero code
    chk("cal exit", 32'h0, driver_impedance_calibration);
    chk("complStrobe used", 32'h0, complStrobe);
    chk("readAllowed relock", 32'h0, readAllowed);
    $display("t_dll done");
  endtask : t_dll
  task automatic t_burst();
    logic [2:0] seen [14];
    logic [6:0] cs [4] = '{7'h3d, 7'h36, 7'h23, 7'h29};
    logic [31:0] d;
    logic s, ok, hit, l8;
    for (int c = 0; c < 4; c++) begin
      ctrl_model_i.mode_set(2'h0, {9'h000, cs[c][3], cs[c][6:4]}, 1'b1);
      l8 = (cs[c][6:4] == BL_CODE_8);
      apb(1'b1, OFS_BURST, {29'h0, cs[c][2:0]}, d, s);
      apb(1'b1, OFS_CTRL, 32'h2, d, s);
      for (int i = 0; i < 14; i++) begin
        @(negedge clock);
        seen[i] = burstColumn;
      end
      hit = 1'b0;
      for (int o = 0; o < 6; o++) begin
        ok = 1'b1;
        for (int i = 0; i < (l8 ? 8 : 4); i++) begin
          ok &= (seen[o + i] === col_at(cs[c][2:0], cs[c][3], l8, i));
        end
        hit |= ok;
      end
      chk("burst column order", 32'h1, hit);
    end
    $display("t_burst done");
  endtask : t_burst
  initial begin
    rst_b = 1'b0;
    strobeN = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    t_load();
    t_dll();
    t_burst();
    finish_test();
  end
endmodule : ddr2_mode_register_programming_tb
